// file: rtl/wqs_wiper_ctrl.sv
/*
 * Quad 256-position wiper control: selectable three-wire or two-wire slave,
 * four wiper registers, per-channel and global shutdown, tap decode.
 * Assumes core_clk_i is far faster than the two-wire clock and that chip
 * select stays high for several core cycles between three-wire frames.
 */
`timescale 1ns/100ps
`include "wqs_cfg.svh"

module wqs_wiper_ctrl #(
   parameter int NUM_CH = 4,
   parameter int CODE_W = 8,
   parameter int TAPS = 256
) (
   input wire logic core_clk_i, // Core clock, 25 MHz
   input wire logic rst_n_i, // Power-on reset, synchronous, active low
   input wire logic interface_select_pin_i, // Strap: low three-wire, high two-wire
   input wire logic spi_sclk_i, // Three-wire link clock
   input wire logic spi_cs_n_i, // Three-wire chip select, active low
   input wire logic serial_in_i, // Three-wire serial data
   input wire logic scl_i, // Two-wire clock
   input wire logic sda_i, // Two-wire data, pin level
   output logic sda_o, // Two-wire data drive value, always low
   output logic sda_oe_o, // Two-wire data pulled low when high
   input wire logic bus_addr_strap_high_i, // Address strap, upper
   input wire logic bus_addr_strap_low_i, // Address strap, lower
   input wire logic global_shutdown_n_i, // All channels shut while low
   input wire logic wiper_reset_n_i, // Wipers to midscale while low
   output logic [1:0] gp_out_o, // {two, one} general outputs
   output logic [NUM_CH-1:0][CODE_W-1:0] wiper_code_o, // Stored codes
   output logic [NUM_CH-1:0] chan_shutdown_o, // Channel in shutdown state
   output logic [NUM_CH-1:0][TAPS-1:0] tap_sel_o // One-hot tap per channel
);

   localparam int SEL_W = $clog2(NUM_CH);

   ////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks: the word formats carry two select bits and a byte
   if (NUM_CH != 4 || CODE_W != 8 || TAPS != (1 << CODE_W)) begin : g_bad_param
      $error("wqs_wiper_ctrl supports only four channels of 8-bit codes");
   end

   // One-hot tap from a code; code zero is the bottom tap, all ones the top
   function automatic logic [TAPS-1:0] tap_decode(input logic [CODE_W-1:0] code);
      logic [TAPS-1:0] hot;
      hot = '0;
      hot[code] = 1'b1;
      return hot;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   localparam int NSYNC = 8;
   logic [NSYNC-1:0] pins_raw;
   logic [NSYNC-1:0] pins_s;
   logic sel_pin_s;
   logic scl_s;
   logic sda_s;
   logic cs_n_s;
   logic strap_hi_s;
   logic strap_lo_s;
   logic gshut_n_s;
   logic wreset_n_s;

   assign pins_raw = {interface_select_pin_i, scl_i, sda_i, spi_cs_n_i,
                      bus_addr_strap_high_i, bus_addr_strap_low_i,
                      global_shutdown_n_i, wiper_reset_n_i};

   wqs_sync #(
      .W(NSYNC)
   ) u_sync (
      .clk_i(core_clk_i),
      .d_i(pins_raw),
      .q_o(pins_s)
   );

   assign {sel_pin_s, scl_s, sda_s, cs_n_s, strap_hi_s, strap_lo_s,
           gshut_n_s, wreset_n_s} = pins_s;

   ////////////////////////////////////////////////////////////////////////////////
   // Three-wire shift register on the link clock
   logic [`WQS_SPI_WORD_W-1:0] spi_word;

   wqs_spi_shift u_spi (
      .spi_sclk_i(spi_sclk_i),
      .spi_cs_n_i(spi_cs_n_i),
      .serial_in_i(serial_in_i),
      .word_o(spi_word)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Edge history of the synchronised pins and the captured strap
   wqs_pkg::wqs_mode_t mode_reg;
   wqs_pkg::wqs_mode_t mode_next;
   logic scl_d_reg;
   logic sda_d_reg;
   logic cs_n_d_reg;
   logic scl_d_next;
   logic sda_d_next;
   logic cs_n_d_next;

   // Strap is caught while reset is held, then frozen until the next reset
   always_comb begin
      mode_next = mode_reg;
      if (!rst_n_i) begin
         mode_next = sel_pin_s ? wqs_pkg::WQS_MODE_I2C : wqs_pkg::WQS_MODE_SPI;
      end
      scl_d_next = rst_n_i ? scl_s : 1'b1;
      sda_d_next = rst_n_i ? sda_s : 1'b1;
      cs_n_d_next = rst_n_i ? cs_n_s : 1'b1;
   end

   always_ff @(posedge core_clk_i) begin
      mode_reg <= mode_next;
      scl_d_reg <= scl_d_next;
      sda_d_reg <= sda_d_next;
      cs_n_d_reg <= cs_n_d_next;
   end

   logic scl_rise;
   logic scl_fall;
   logic i2c_start;
   logic i2c_stop;
   logic spi_load;

   // Bus conditions; the rising edge of chip select marks a finished frame
   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   assign i2c_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign i2c_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
   // The link clock is idle once chip select is high, so the word is stable
   assign spi_load = cs_n_s & ~cs_n_d_reg & (mode_reg == wqs_pkg::WQS_MODE_SPI);

   ////////////////////////////////////////////////////////////////////////////////
   // Two-wire slave sequencer
   wqs_pkg::wqs_i2c_state_t st_reg;
   wqs_pkg::wqs_i2c_state_t st_next;
   logic [3:0] bit_cnt_reg;
   logic [3:0] bit_cnt_next;
   logic [7:0] sh_reg;
   logic [7:0] sh_next;
   logic read_dir_reg;
   logic read_dir_next;
   logic sda_oe_reg;
   logic sda_oe_next;
   logic instr_ev;
   logic data_ev;
   logic [CODE_W-1:0] read_byte;
   logic addr_match;

   assign addr_match = (sh_reg[7:1] == {`WQS_ADDR_PREFIX, strap_hi_s, strap_lo_s});

   // Bytes sampled on rising clock, our drive changes after the falling one
   always_comb begin
      st_next = st_reg;
      bit_cnt_next = bit_cnt_reg;
      sh_next = sh_reg;
      read_dir_next = read_dir_reg;
      sda_oe_next = sda_oe_reg;
      instr_ev = 1'b0;
      data_ev = 1'b0;
      if (!rst_n_i || mode_reg != wqs_pkg::WQS_MODE_I2C) begin
         st_next = wqs_pkg::WQS_IDLE;
         bit_cnt_next = 4'h0;
         sda_oe_next = 1'b0;
         read_dir_next = 1'b0;
         sh_next = 8'h00;
      end else if (i2c_start) begin
         st_next = wqs_pkg::WQS_ADDR;
         bit_cnt_next = 4'h0;
         sda_oe_next = 1'b0;
      end else if (i2c_stop) begin
         st_next = wqs_pkg::WQS_IDLE;
         sda_oe_next = 1'b0;
      end else begin
         unique case (st_reg)
            wqs_pkg::WQS_IDLE: begin
               sda_oe_next = 1'b0;
            end
            wqs_pkg::WQS_ADDR, wqs_pkg::WQS_INSTR, wqs_pkg::WQS_DATA: begin
               if (scl_rise && bit_cnt_reg < `WQS_BYTE_BITS) begin
                  sh_next = {sh_reg[6:0], sda_s};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == `WQS_BYTE_BITS) begin
                  bit_cnt_next = 4'h0;
                  if (st_reg == wqs_pkg::WQS_ADDR) begin
                     if (addr_match) begin
                        st_next = wqs_pkg::WQS_ADDR_ACK;
                        sda_oe_next = 1'b1;
                        read_dir_next = sh_reg[0];
                     end else begin
                        st_next = wqs_pkg::WQS_IDLE;
                     end
                  end else if (st_reg == wqs_pkg::WQS_INSTR) begin
                     st_next = wqs_pkg::WQS_INSTR_ACK;
                     sda_oe_next = 1'b1;
                     instr_ev = 1'b1;
                  end else begin
                     st_next = wqs_pkg::WQS_DATA_ACK;
                     sda_oe_next = 1'b1;
                     data_ev = 1'b1;
                  end
               end
            end
            wqs_pkg::WQS_ADDR_ACK: begin
               if (scl_fall) begin
                  if (read_dir_reg) begin
                     st_next = wqs_pkg::WQS_READ;
                     sh_next = read_byte;
                     sda_oe_next = ~read_byte[7];
                     bit_cnt_next = 4'h1;
                  end else begin
                     st_next = wqs_pkg::WQS_INSTR;
                     sda_oe_next = 1'b0;
                  end
               end
            end
            wqs_pkg::WQS_INSTR_ACK, wqs_pkg::WQS_DATA_ACK: begin
               // Further data bytes rewrite the same channel
               if (scl_fall) begin
                  st_next = wqs_pkg::WQS_DATA;
                  sda_oe_next = 1'b0;
               end
            end
            wqs_pkg::WQS_READ: begin
               if (scl_fall) begin
                  if (bit_cnt_reg == `WQS_BYTE_BITS) begin
                     st_next = wqs_pkg::WQS_READ_ACK;
                     sda_oe_next = 1'b0;
                  end else begin
                     sh_next = {sh_reg[6:0], 1'b0};
                     sda_oe_next = ~sh_reg[6];
                     bit_cnt_next = bit_cnt_reg + 4'h1;
                  end
               end
            end
            wqs_pkg::WQS_READ_ACK: begin
               // A master acknowledge asks for the same byte again
               if (scl_rise && sda_s) begin
                  st_next = wqs_pkg::WQS_IDLE;
               end else if (scl_fall) begin
                  st_next = wqs_pkg::WQS_READ;
                  sh_next = read_byte;
                  sda_oe_next = ~read_byte[7];
                  bit_cnt_next = 4'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      st_reg <= st_next;
      bit_cnt_reg <= bit_cnt_next;
      sh_reg <= sh_next;
      read_dir_reg <= read_dir_next;
      sda_oe_reg <= sda_oe_next;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Wiper registers, channel shutdown, selection and general outputs
   logic [NUM_CH-1:0][CODE_W-1:0] wiper_reg;
   logic [NUM_CH-1:0][CODE_W-1:0] wiper_next;
   logic [NUM_CH-1:0] sw_shut_reg;
   logic [NUM_CH-1:0] sw_shut_next;
   logic [SEL_W-1:0] last_sel_reg;
   logic [SEL_W-1:0] last_sel_next;
   logic mid_pending_reg;
   logic mid_pending_next;
   logic [1:0] gp_reg;
   logic [1:0] gp_next;
   logic [SEL_W-1:0] ins_sel;
   logic [SEL_W-1:0] spi_sel;

   assign ins_sel = {sh_reg[`WQS_INS_SEL_HI], sh_reg[`WQS_INS_SEL_LO]};
   assign spi_sel = {spi_word[`WQS_SPI_SEL_HI], spi_word[`WQS_SPI_SEL_LO]};
   assign read_byte = wiper_reg[last_sel_reg];

   // Reset pin wins over serial writes; the midscale it leaves is kept
   always_comb begin
      wiper_next = wiper_reg;
      sw_shut_next = sw_shut_reg;
      last_sel_next = last_sel_reg;
      mid_pending_next = mid_pending_reg;
      gp_next = gp_reg;
      if (!rst_n_i) begin
         wiper_next = {NUM_CH{`WQS_MIDSCALE}};
         sw_shut_next = '0;
         last_sel_next = '0;
         mid_pending_next = 1'b0;
         gp_next = 2'b00;
      end else if (!wreset_n_s) begin
         wiper_next = {NUM_CH{`WQS_MIDSCALE}};
      end else begin
         if (spi_load) begin
            wiper_next[spi_sel] = spi_word[`WQS_SPI_CODE_HI:0];
            last_sel_next = spi_sel;
         end
         if (instr_ev) begin
            last_sel_next = ins_sel;
            sw_shut_next[ins_sel] = sh_reg[`WQS_INS_SHUT];
            gp_next = {sh_reg[`WQS_INS_GP2], sh_reg[`WQS_INS_GP1]};
            mid_pending_next = sh_reg[`WQS_INS_MID];
            if (sh_reg[`WQS_INS_MID]) begin
               wiper_next[ins_sel] = `WQS_MIDSCALE;
            end
         end
         // A midscale instruction keeps the channel there despite its data byte
         if (data_ev && !mid_pending_reg) begin
            wiper_next[last_sel_reg] = sh_reg;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      wiper_reg <= wiper_next;
      sw_shut_reg <= sw_shut_next;
      last_sel_reg <= last_sel_next;
      mid_pending_reg <= mid_pending_next;
      gp_reg <= gp_next;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output stage: shutdown and tap decode registered from the stored codes
   logic [NUM_CH-1:0] shut_out_reg;
   logic [NUM_CH-1:0] shut_out_next;
   logic [NUM_CH-1:0][TAPS-1:0] tap_reg;
   logic [NUM_CH-1:0][TAPS-1:0] tap_next;
   logic [1:0] gp_out_reg;
   logic [1:0] gp_out_next;

   // Shut channels show no tap; the code stays and returns on exit
   always_comb begin
      gp_out_next = (mode_reg == wqs_pkg::WQS_MODE_I2C) ? gp_reg : 2'b00;
      for (int i = 0; i < NUM_CH; i++) begin
         shut_out_next[i] = sw_shut_reg[i] | ~gshut_n_s;
         tap_next[i] = shut_out_next[i] ? '0 : tap_decode(wiper_reg[i]);
      end
      if (!rst_n_i) begin
         shut_out_next = '0;
         gp_out_next = 2'b00;
         for (int i = 0; i < NUM_CH; i++) begin
            tap_next[i] = tap_decode(`WQS_MIDSCALE);
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      shut_out_reg <= shut_out_next;
      tap_reg <= tap_next;
      gp_out_reg <= gp_out_next;
   end

   assign sda_o = 1'b0; // Open drain: only the enable moves
   assign sda_oe_o = sda_oe_reg;
   assign gp_out_o = gp_out_reg;
   assign wiper_code_o = wiper_reg;
   assign chan_shutdown_o = shut_out_reg;
   assign tap_sel_o = tap_reg;

endmodule

// file: common/wqs_cfg.svh
/*
 * Constants of the quad wiper serial control block: word field positions,
 * instruction bit positions, bus address prefix and reset values.
 * Assumes it is included by bare name wherever the numbers are needed.
 */
`ifndef WQS_CFG_SVH
`define WQS_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Wiper codes
`define WQS_MIDSCALE 8'h80
`define WQS_CODE_ZERO 8'h00

////////////////////////////////////////////////////////////////////////////////
// Three-wire word: channel select on top, code below, MSB first
`define WQS_SPI_WORD_W 10
`define WQS_SPI_SEL_HI 9
`define WQS_SPI_SEL_LO 8
`define WQS_SPI_CODE_HI 7

////////////////////////////////////////////////////////////////////////////////
// Two-wire instruction byte bit positions
`define WQS_INS_SEL_HI 6
`define WQS_INS_SEL_LO 5
`define WQS_INS_MID 4
`define WQS_INS_SHUT 3
`define WQS_INS_GP1 2
`define WQS_INS_GP2 1

////////////////////////////////////////////////////////////////////////////////
// Two-wire address: fixed upper bits, straps below, byte length
`define WQS_ADDR_PREFIX 5'h0B
`define WQS_BYTE_BITS 4'h8

`endif

// file: common/wqs_pkg.sv
/*
 * Types shared by the quad wiper serial control block.
 * Assumes nothing of its surroundings; constants live in wqs_cfg.svh.
 */
package wqs_pkg;

   // Interface chosen by the select strap
   typedef enum logic {
      WQS_MODE_SPI,
      WQS_MODE_I2C
   } wqs_mode_t;

   // Two-wire slave sequencer
   typedef enum logic [3:0] {
      WQS_IDLE,
      WQS_ADDR,
      WQS_ADDR_ACK,
      WQS_INSTR,
      WQS_INSTR_ACK,
      WQS_DATA,
      WQS_DATA_ACK,
      WQS_READ,
      WQS_READ_ACK
   } wqs_i2c_state_t;

endpackage

// file: rtl/wqs_sync.sv
/*
 * Two flip-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level; no bus coherency is given across bits.
 */
`timescale 1ns/100ps

module wqs_sync #(
   parameter int W = 1
) (
   input wire logic clk_i, // Destination clock
   input wire logic [W-1:0] d_i, // Asynchronous levels
   output logic [W-1:0] q_o // Synchronised levels
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // No reset here so a strap can be sampled through it while reset is held
   always_ff @(posedge clk_i) begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
   end

   assign q_o = q_reg;

endmodule

// file: rtl/wqs_spi_shift.sv
/*
 * Three-wire serial input shift register, clocked by the link clock.
 * Assumes the link clock stands still while chip select is high, so the
 * word is stable for the core domain to take after chip select rises.
 */
`timescale 1ns/100ps
`include "wqs_cfg.svh"

module wqs_spi_shift (
   input wire logic spi_sclk_i, // Link clock from the host
   input wire logic spi_cs_n_i, // Chip select, active low
   input wire logic serial_in_i, // Serial data in
   output logic [`WQS_SPI_WORD_W-1:0] word_o // Last ten bits shifted in
);

   logic [`WQS_SPI_WORD_W-1:0] shift_reg;
   logic [`WQS_SPI_WORD_W-1:0] shift_next;

   ////////////////////////////////////////////////////////////////////////////////
   // Shift on rising edges inside the frame; older bits fall off the top
   always_comb begin
      shift_next = shift_reg;
      if (!spi_cs_n_i) begin
         shift_next = {shift_reg[`WQS_SPI_WORD_W-2:0], serial_in_i};
      end
   end

   always_ff @(posedge spi_sclk_i) begin
      shift_reg <= shift_next;
   end

   assign word_o = shift_reg;

endmodule

// file: dv/wqs_checker.sv
/*
 * Port-level checker of the quad wiper control, bound into its top module.
 * Assumes one core clock domain and straps that only move while reset is held.
 */
`timescale 1ns/100ps

module wqs_checker #(
   parameter int NUM_CH = 4,
   parameter int CODE_W = 8,
   parameter int TAPS = 256
) (
   input wire logic core_clk_i, // Core clock
   input wire logic rst_n_i, // Reset, active low
   input wire logic interface_select_pin_i, // Mode strap
   input wire logic scl_i, // Two-wire clock level
   input wire logic global_shutdown_n_i, // Shut all, active low
   input wire logic wiper_reset_n_i, // Midscale, active low
   input wire logic sda_oe_o, // Data pulled low
   input wire logic [1:0] gp_out_o, // General outputs
   input wire logic [NUM_CH-1:0][CODE_W-1:0] wiper_code_o, // Stored codes
   input wire logic [NUM_CH-1:0] chan_shutdown_o, // Shutdown flags
   input wire logic [NUM_CH-1:0][TAPS-1:0] tap_sel_o // One-hot taps
);

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   ////////////////////////////////////////////////////////////////////////////////
   // Preset, reset pin and shutdown pin
   property p_preset;
      $rose(rst_n_i) |-> wiper_code_o == {4{8'h80}} && gp_out_o == 2'h0;
   endproperty
   a_preset: assert property (p_preset)
      else $error("Wipers not at midscale after reset");
   property p_wres;
      !wiper_reset_n_i [*5] |-> wiper_code_o == {4{8'h80}};
   endproperty
   a_wres: assert property (p_wres)
      else $error("Reset pin did not force midscale");
   property p_gshut;
      !global_shutdown_n_i [*5] |-> chan_shutdown_o == 4'hF;
   endproperty
   a_gshut: assert property (p_gshut)
      else $error("Shutdown pin did not shut every channel");

   ////////////////////////////////////////////////////////////////////////////////
   // Tap decode; a shut channel shows no tap at all
   property p_tap_off;
      chan_shutdown_o[2] [*2] |-> tap_sel_o[2] == 256'h0;
   endproperty
   a_tap_off: assert property (p_tap_off)
      else $error("Shut channel still selects a tap");
   property p_decode;
      !chan_shutdown_o[2] && !$past(chan_shutdown_o[2]) && $stable(wiper_code_o[2])
         |-> tap_sel_o[2] == (256'h1 << wiper_code_o[2]);
   endproperty
   a_decode: assert property (p_decode)
      else $error("Tap does not match stored code");

   ////////////////////////////////////////////////////////////////////////////////
   // Two-wire drive moves only with the clock low; silent in three-wire mode
   property p_oe_low;
      $changed(sda_oe_o) |-> !scl_i;
   endproperty
   a_oe_low: assert property (p_oe_low)
      else $error("Data drive changed while clock high");
   property p_spi_no_oe;
      !interface_select_pin_i |-> !sda_oe_o;
   endproperty
   a_spi_no_oe: assert property (p_spi_no_oe)
      else $error("Two-wire drive in three-wire mode");
   property p_spi_gp;
      !interface_select_pin_i |-> gp_out_o == 2'h0;
   endproperty
   a_spi_gp: assert property (p_spi_gp)
      else $error("General outputs set in three-wire mode");

endmodule

bind wqs_wiper_ctrl wqs_checker #(.NUM_CH(NUM_CH), .CODE_W(CODE_W), .TAPS(TAPS)) wqs_checker_i (
   .core_clk_i, .rst_n_i, .interface_select_pin_i, .scl_i, .global_shutdown_n_i,
   .wiper_reset_n_i, .sda_oe_o, .gp_out_o, .wiper_code_o, .chan_shutdown_o, .tap_sel_o
);

// file: dv/wqs_host.sv
/*
 * Host model: three-wire master on a 30 ns link clock and a two-wire master.
 * Assumes the bench resolves the data line with a pull-up.
 */
`timescale 1ns/100ps

module wqs_host (
   output logic spi_sclk_o, // Link clock, still outside frames
   output logic spi_cs_n_o, // Chip select, active low
   output logic serial_in_o, // Serial data
   output logic scl_o, // Two-wire clock
   output logic sda_pull_o, // High while host pulls data low
   input wire logic sda_i // Resolved data line
);
   localparam int Q = 200; // Quarter bit; slow enough for the synchronisers
   logic r;

   // Idle levels at time zero
   initial begin
      spi_sclk_o = 1'b0;
      spi_cs_n_o = 1'b1;
      serial_in_o = 1'b0;
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Three-wire frame of n bits, MSB first; data moves with the clock low
   task automatic spi(input logic [11:0] w, input int n);
      spi_cs_n_o = 1'b0;
      #20;
      for (int i = n - 1; i >= 0; i--) begin
         serial_in_o = w[i];
         #15 spi_sclk_o = 1'b1;
         #15 spi_sclk_o = 1'b0;
      end
      #20 spi_cs_n_o = 1'b1;
      serial_in_o = ~serial_in_o; // Stale data must not look valid
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Two-wire bit, start, stop and bytes
   task automatic bit_io(input logic b, output logic v);
      #Q sda_pull_o = !b;
      #Q scl_o = 1'b1;
      #Q v = sda_i;
      #Q scl_o = 1'b0;
   endtask
   task automatic start();
      #Q sda_pull_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q sda_pull_o = 1'b1;
      #Q scl_o = 1'b0;
   endtask
   task automatic stop();
      #Q sda_pull_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_pull_o = 1'b0;
      #Q;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic nack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(nack, r);
   endtask
endmodule

// file: dv/testbench.sv
/*
 * Self-checking bench of the quad wiper control with the host model as master.
 * Assumes straps move only while reset is held; address straps are 2'h2.
 */
`timescale 1ns/100ps

module testbench;
   logic core_clk_i, rst_n_i, interface_select_pin_i, spi_sclk_i, spi_cs_n_i, serial_in_i;
   logic scl_i, sda_o, sda_oe_o, sda_pull, bus_addr_strap_high_i, bus_addr_strap_low_i;
   logic global_shutdown_n_i, wiper_reset_n_i, a;
   logic [1:0] gp_out_o;
   logic [7:0] d;
   logic [3:0][7:0] wiper_code_o;
   logic [3:0] chan_shutdown_o;
   logic [3:0][255:0] tap_sel_o;
   wire logic sda_i;
   int fails, check_count;

   // Open-drain data line with pull-up
   assign sda_i = !sda_pull && (sda_oe_o ? sda_o : 1'b1);

   // Core clock, 40 ns
   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   wqs_wiper_ctrl wqs_wiper_ctrl_i (
      .core_clk_i, .rst_n_i, .interface_select_pin_i, .spi_sclk_i, .spi_cs_n_i, .serial_in_i,
      .scl_i, .sda_i, .sda_o, .sda_oe_o, .bus_addr_strap_high_i, .bus_addr_strap_low_i,
      .global_shutdown_n_i, .wiper_reset_n_i, .gp_out_o, .wiper_code_o, .chan_shutdown_o,
      .tap_sel_o
   );
   wqs_host wqs_host_i (
      .spi_sclk_o(spi_sclk_i), .spi_cs_n_o(spi_cs_n_i), .serial_in_o(serial_in_i),
      .scl_o(scl_i), .sda_pull_o(sda_pull), .sda_i
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic do_reset(input logic mode);
      interface_select_pin_i = mode;
      rst_n_i = 1'b0;
      cyc(20);
      rst_n_i = 1'b1;
      cyc(4);
   endtask
   // Two-wire write; every byte goes out so an ignoring device is really exercised
   task automatic wr(input logic [1:0] ch, input logic [3:0] f, input logic [7:0] v,
                     input logic ak);
      wqs_host_i.start();
      wqs_host_i.wbyte({5'h0B, 2'h2, 1'b0}, a);
      check("addr ack", {7'h0, ak}, {7'h0, a});
      wqs_host_i.wbyte({1'b0, ch, f, 1'b0}, a);
      check("instr ack", {7'h0, ak}, {7'h0, a});
      wqs_host_i.wbyte(v, a);
      check("data ack", {7'h0, ak}, {7'h0, a});
      wqs_host_i.stop();
      cyc(8);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_spi();
      logic [7:0] codes [4] = '{8'h00, 8'h01, 8'hFE, 8'hFF};
      do_reset(1'b0);
      for (int c = 0; c < 4; c++) check("preset", 8'h80, wiper_code_o[c]);
      for (int c = 0; c < 4; c++) begin
         wqs_host_i.spi({2'h0, 2'(c), codes[c]}, 10);
         cyc(8);
         check("spi code", codes[c], wiper_code_o[c]);
         check("tap", 8'h1, {7'h0, tap_sel_o[c][codes[c]]});
      end
      wqs_host_i.spi({2'h3, 2'h1, 8'h5A}, 12);
      cyc(8);
      check("last ten", 8'h5A, wiper_code_o[1]);
      wr(2'h0, 4'h0, 8'h77, 1'b0);
      check("two-wire ignored", 8'h00, wiper_code_o[0]);
      $display("t_spi done");
   endtask
   task automatic t_shut();
      global_shutdown_n_i = 1'b0;
      cyc(6);
      check("all shut", 8'h0F, {4'h0, chan_shutdown_o});
      wqs_host_i.spi({2'h0, 2'h2, 8'h33}, 10);
      cyc(8);
      check("write in shutdown", 8'h33, wiper_code_o[2]);
      check("tap off", 8'h0, {7'h0, |tap_sel_o[2]});
      global_shutdown_n_i = 1'b1;
      cyc(6);
      check("tap back", 8'h1, {7'h0, tap_sel_o[2][8'h33]});
      check("code kept", 8'hFF, wiper_code_o[3]);
      wiper_reset_n_i = 1'b0;
      cyc(6);
      wiper_reset_n_i = 1'b1;
      cyc(6);
      for (int c = 0; c < 4; c++) check("wiper reset", 8'h80, wiper_code_o[c]);
      $display("t_shut done");
   endtask
   task automatic t_i2c();
      do_reset(1'b1);
      wr(2'h2, 4'h2, 8'h3C, 1'b1);
      check("i2c code", 8'h3C, wiper_code_o[2]);
      check("gp one", 8'h01, {6'h0, gp_out_o});
      wqs_host_i.spi({2'h0, 2'h3, 8'h11}, 10);
      cyc(8);
      check("spi ignored", 8'h80, wiper_code_o[3]);
      wqs_host_i.start();
      wqs_host_i.wbyte({5'h0B, 2'h2, 1'b1}, a);
      check("read ack", 8'h1, {7'h0, a});
      wqs_host_i.rbyte(1'b0, d);
      check("read data", 8'h3C, d);
      wqs_host_i.rbyte(1'b1, d);
      wqs_host_i.stop();
      check("read again", 8'h3C, d);
      wqs_host_i.start();
      wqs_host_i.wbyte({5'h0B, 2'h1, 1'b0}, a);
      check("foreign addr", 8'h0, {7'h0, a});
      wqs_host_i.wbyte(8'h00, a);
      wqs_host_i.wbyte(8'h11, a);
      wqs_host_i.stop();
      cyc(8);
      check("foreign data", 8'h80, wiper_code_o[0]);
      check("foreign gp", 8'h01, {6'h0, gp_out_o});
      wr(2'h2, 4'h9, 8'h55, 1'b1);
      check("midscale", 8'h80, wiper_code_o[2]);
      check("gp two", 8'h02, {6'h0, gp_out_o});
      wr(2'h1, 4'h4, 8'h80, 1'b1);
      check("one shut", 8'h02, {4'h0, chan_shutdown_o});
      check("shut code", 8'h80, wiper_code_o[1]);
      wr(2'h2, 4'h0, 8'h80, 1'b1);
      check("other cleared", 8'h02, {4'h0, chan_shutdown_o});
      wr(2'h1, 4'h0, 8'h80, 1'b1);
      check("restored", 8'h00, {4'h0, chan_shutdown_o});
      check("restored tap", 8'h1, {7'h0, tap_sel_o[1][8'h80]});
      $display("t_i2c done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_n_i = 1'b0;
      interface_select_pin_i = 1'b0;
      bus_addr_strap_high_i = 1'b1;
      bus_addr_strap_low_i = 1'b0;
      global_shutdown_n_i = 1'b1;
      wiper_reset_n_i = 1'b1;
      t_spi();
      t_shut();
      t_i2c();
      end_of_test();
   end

   // Watchdog against a hung run
   initial begin
      #2000000;
      fails++;
      end_of_test();
   end
endmodule
